// [hdl/dswpc_top.sv]
// Write port capture of a double-data-rate burst SRAM
// Overview of operation
// - The write port select is active low and is sampled on the true clock rising edge only.
// - A low write port select on that edge starts a write with the data present as first beat; its address comes on the complement edge.
// - A high write port select leaves the write port deselected and nothing is stored.
// - On the nibble variant two active-low nibble masks, sampled on both clocks, pick stored nibbles.
// - A nibble whose mask is inactive keeps its previous contents.
// - Byte masks are sampled on both clock edges together with the data beat they qualify.
// - Mask 0 covers bits 8..0, mask 1 bits 17..9, mask 2 bits 26..18, mask 3 bits 35..27.
// - A lane whose byte mask is inactive is ignored for that beat and stays unchanged.
// - The shared address is taken as read address on the true edge, write address on the complement.
// - The address is 22 bits for 8/9-bit, 21 for 18-bit and 20 for 36-bit variants.
// - Storage is two equal arrays so that one address selects a pair of words.
// - Address inputs are ignored on an edge whose port is deselected.
// - Write data is sampled on both the true and complement clock rising edges during writes.
// - A low read port select on the true edge starts a read of a two-word burst.
`timescale 1ns/1ps
`default_nettype none
module dswpc_top
   import dswpc_pkg::*;
#(
   parameter int MEM_AW = DSWPC_MEM_AW
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Input clock pair from the controller
   input wire logic k_clk,
   input wire logic k_clk_n,
   // Write and read port pins
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic [DSWPC_ADDR_W-1:0] addr,
   input wire logic [DSWPC_DATA_W-1:0] data,
   input wire logic [DSWPC_LANES-1:0] byte_write_mask_n,
   // Write commit report
   output logic wr_done_ff,
   output logic [DSWPC_ADDR_W-1:0] wr_addr_ff,
   // Read burst start
   output logic rd_start_ff,
   output logic [DSWPC_ADDR_W-1:0] rd_addr_ff,
   output logic [DSWPC_DATA_W-1:0] rd_word0_ff,
   output logic [DSWPC_DATA_W-1:0] rd_word1_ff
);
   dswpc_pins_s pin_s1_ff;
   dswpc_pins_s pin_s2_ff;
   logic [2:0] k_sync_ff;
   logic [2:0] kn_sync_ff;
   logic wr_arm_ff;
   logic [DSWPC_DATA_W-1:0] beat0_data_ff;
   logic [DSWPC_LANES-1:0] beat0_mask_n_ff;
   logic [DSWPC_DATA_W-1:0] rd_data0;
   logic [DSWPC_DATA_W-1:0] rd_data1;
   dswpc_pins_s pin_now;

   assign pin_now = '{
      write_port_select_n: write_port_select_n,
      read_port_select_n: read_port_select_n,
      addr: addr,
      data: data,
      byte_write_mask_n: byte_write_mask_n
   };

   // Two-flop pin synchronisers, clocks get a third stage for edges
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_s1_ff <= DSWPC_PINS_IDLE;
         pin_s2_ff <= DSWPC_PINS_IDLE;
         k_sync_ff <= 3'h0;
         // Complement clock idles high, so no false edge after reset
         kn_sync_ff <= 3'h7;
      end else begin
         pin_s1_ff <= pin_now;
         pin_s2_ff <= pin_s1_ff;
         k_sync_ff <= {k_sync_ff[1:0], k_clk};
         kn_sync_ff <= {kn_sync_ff[1:0], k_clk_n};
      end
   end

   wire k_rise = k_sync_ff[1] && !k_sync_ff[2];
   wire kn_rise = kn_sync_ff[1] && !kn_sync_ff[2];
   // select seen only on true edge
   wire wr_sel = k_rise && !pin_s2_ff.write_port_select_n;
   wire rd_sel = k_rise && !pin_s2_ff.read_port_select_n;
   // write address only on complement edge of an armed write
   wire wr_commit = kn_rise && wr_arm_ff;
   wire [MEM_AW-1:0] wr_idx = pin_s2_ff.addr[MEM_AW-1:0];
   wire [MEM_AW-1:0] rd_idx = pin_s2_ff.addr[MEM_AW-1:0];

   // write armed by true edge, dropped after complement edge
   wire nxt_wr_arm = wr_sel ? 1'b1 : (kn_rise ? 1'b0 : wr_arm_ff);

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_arm_ff <= 1'b0;
      end else begin
         wr_arm_ff <= nxt_wr_arm;
      end
   end

   // first beat and its masks held until the complement edge
   always_ff @(posedge clk) begin
      if (reset) begin
         beat0_data_ff <= '0;
         beat0_mask_n_ff <= '1;
      end else if (wr_sel) begin
         beat0_data_ff <= pin_s2_ff.data;
         beat0_mask_n_ff <= pin_s2_ff.byte_write_mask_n;
      end
   end

   // two arrays, one word of the pair each; active-low masks
   dswpc_bank #(.AW(MEM_AW), .LW(DSWPC_LANE_W), .NL(DSWPC_LANES)) u_bank0 (
      .clk(clk),
      .reset(reset),
      .wr_en(wr_commit),
      .wr_idx(wr_idx),
      .wr_data(beat0_data_ff),
      .lane_en(~beat0_mask_n_ff),
      .rd_idx(rd_idx),
      .rd_data(rd_data0)
   );

   dswpc_bank #(.AW(MEM_AW), .LW(DSWPC_LANE_W), .NL(DSWPC_LANES)) u_bank1 (
      .clk(clk),
      .reset(reset),
      .wr_en(wr_commit),
      .wr_idx(wr_idx),
      .wr_data(pin_s2_ff.data),
      .lane_en(~pin_s2_ff.byte_write_mask_n),
      .rd_idx(rd_idx),
      .rd_data(rd_data1)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_done_ff <= 1'b0;
         wr_addr_ff <= '0;
      end else begin
         wr_done_ff <= wr_commit;
         if (wr_commit) begin
            wr_addr_ff <= pin_s2_ff.addr;
         end
      end
   end

   // read address and two-word burst on the true edge
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_start_ff <= 1'b0;
         rd_addr_ff <= '0;
         rd_word0_ff <= '0;
         rd_word1_ff <= '0;
      end else begin
         rd_start_ff <= rd_sel;
         if (rd_sel) begin
            rd_addr_ff <= pin_s2_ff.addr;
            rd_word0_ff <= rd_data0;
            rd_word1_ff <= rd_data1;
         end
      end
   end

   sequence write_selected_s;
      k_rise && !pin_s2_ff.write_port_select_n;
   endsequence

   sequence write_armed_s;
      wr_arm_ff;
   endsequence

   arm_on_select_a: assert property (@(posedge clk) disable iff (reset)
      write_selected_s |=> write_armed_s)
      else $error("write not armed after select");

   deselect_no_arm_a: assert property (@(posedge clk) disable iff (reset)
      k_rise && pin_s2_ff.write_port_select_n |=> !wr_arm_ff)
      else $error("write armed while deselected");

   beat0_capture_a: assert property (@(posedge clk) disable iff (reset)
      write_selected_s |=> beat0_data_ff == $past(pin_s2_ff.data))
      else $error("first beat not captured");

   mask_capture_a: assert property (@(posedge clk) disable iff (reset)
      write_selected_s |=> beat0_mask_n_ff == $past(pin_s2_ff.byte_write_mask_n))
      else $error("first beat masks not captured");

   write_commit_a: assert property (@(posedge clk) disable iff (reset)
      kn_rise && wr_arm_ff |=> wr_done_ff && wr_addr_ff == $past(pin_s2_ff.addr) && !wr_arm_ff)
      else $error("write address not taken on complement edge");

   idle_addr_a: assert property (@(posedge clk) disable iff (reset)
      !wr_commit |=> !wr_done_ff && $stable(wr_addr_ff))
      else $error("write address taken while deselected");

   read_start_a: assert property (@(posedge clk) disable iff (reset)
      rd_sel |=> rd_start_ff && rd_addr_ff == $past(pin_s2_ff.addr))
      else $error("read not started");

   read_ignore_a: assert property (@(posedge clk) disable iff (reset)
      !rd_sel |=> !rd_start_ff && $stable(rd_addr_ff))
      else $error("read address taken while deselected");

   sequence read_selected_s;
      rd_sel;
   endsequence

   true_edge_arm_a: assert property (@(posedge clk) disable iff (reset)
      $rose(wr_arm_ff) |-> $past(k_rise))
      else $error("write armed without a true clock edge");

   beat0_ignore_a: assert property (@(posedge clk) disable iff (reset)
      k_rise && pin_s2_ff.write_port_select_n |=> $stable(beat0_data_ff))
      else $error("write data taken while deselected");

   orphan_edge_a: assert property (@(posedge clk) disable iff (reset)
      kn_rise && !wr_arm_ff |=> !wr_done_ff)
      else $error("complement edge committed without a write");

   read_words_a: assert property (@(posedge clk) disable iff (reset)
      read_selected_s |=> rd_word0_ff === $past(rd_data0) && rd_word1_ff === $past(rd_data1))
      else $error("read burst words not taken");
endmodule
`default_nettype wire

// [hdl/dswpc_pkg.sv]
// Shared widths and pin bundle of the write port capture block
package dswpc_pkg;
   // Thirty-six bit variant: 20 address bits, four 9-bit lanes.
   // Other variants: 18-bit has 21 address bits and 2 lanes; 9-bit has
   // 22 address bits and 1 lane; 8-bit has 22 address bits and two 4-bit nibble lanes.
   // address width of this variant
   localparam int DSWPC_ADDR_W = 20;
   localparam int DSWPC_LANE_W = 9;
   localparam int DSWPC_LANES = 4;
   localparam int DSWPC_DATA_W = DSWPC_LANE_W * DSWPC_LANES;
   // Flip-flop storage index width per array
   localparam int DSWPC_MEM_AW = 4;

   typedef struct packed {
      logic write_port_select_n;
      logic read_port_select_n;
      logic [DSWPC_ADDR_W-1:0] addr;
      logic [DSWPC_DATA_W-1:0] data;
      logic [DSWPC_LANES-1:0] byte_write_mask_n;
   } dswpc_pins_s;

   localparam dswpc_pins_s DSWPC_PINS_IDLE = '{
      write_port_select_n: 1'b1,
      read_port_select_n: 1'b1,
      addr: '0,
      data: '0,
      byte_write_mask_n: '1
   };
endpackage

// [hdl/dswpc_bank.sv]
// One of the two storage arrays with per-lane write enables
`timescale 1ns/1ps
`default_nettype none
module dswpc_bank #(
   parameter int AW = 4,
   parameter int LW = 9,
   parameter int NL = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write side
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [LW*NL-1:0] wr_data,
   input wire logic [NL-1:0] lane_en,
   // Read side
   input wire logic [AW-1:0] rd_idx,
   output logic [LW*NL-1:0] rd_data
);
   logic [AW-1:0] chk_idx_ff;

   always_ff @(posedge clk) begin
      chk_idx_ff <= wr_idx;
   end

   genvar i;
   generate
      for (i = 0; i < NL; i++) begin : g_lane
         // Each lane owns its storage so one process writes it
         logic [LW-1:0] lane_mem_ff [0:(1<<AW)-1];
         logic [LW-1:0] old_lane_ff;
         logic chk_ff;
         assign rd_data[i*LW +: LW] = lane_mem_ff[rd_idx];
         // lane i covers bits i*LW upward
         always_ff @(posedge clk) begin
            if (wr_en && lane_en[i]) begin
               lane_mem_ff[wr_idx] <= wr_data[i*LW +: LW];
            end
         end
         always_ff @(posedge clk) begin
            old_lane_ff <= lane_mem_ff[wr_idx];
            chk_ff <= wr_en && !lane_en[i];
         end
         lane_keep_a: assert property (@(posedge clk) disable iff (reset)
            chk_ff |-> lane_mem_ff[chk_idx_ff] === old_lane_ff)
            else $error("masked lane was overwritten");
      end
   endgenerate
endmodule
`default_nettype wire

// [verification/dswpc_ctrl_model.sv]
// Controller model driving the input clock pair and port pins
`timescale 1ns/1ps
`default_nettype none
module dswpc_ctrl_model
   import dswpc_pkg::*;
(
   // Pins toward the device
   output var dswpc_pins_s pins,
   output logic k_clk,
   output logic k_clk_n
);
   initial begin
      pins = DSWPC_PINS_IDLE;
      k_clk = 1'b0;
      k_clk_n = 1'b1;
   end
   task automatic frame(input logic ws, rs, input logic [19:0] ra, wa,
      input logic [35:0] d0, d1, input logic [3:0] m0, m1);
      pins = '{ws, rs, ra, d0, m0};
      #40;
      k_clk = 1'b1;
      k_clk_n = 1'b0;
      #60;
      pins = '{1'b1, 1'b1, wa, d1, m1};
      #40;
      k_clk = 1'b0;
      k_clk_n = 1'b1;
      #60;
      // Released lines show the inverse, clocks stand still
      pins = '{1'b1, 1'b1, ~wa, ~d1, ~m1};
   endtask
endmodule
`default_nettype wire

// [verification/test_dswpc_top.sv]
// Self-checking bench for the write port capture block
`timescale 1ns/1ps
`default_nettype none
module test_dswpc_top
   import dswpc_pkg::*;
;
   typedef logic [35:0] dswpc_w_t;
   typedef struct packed {
      logic ws;
      logic rs;
      logic [19:0] ra;
      logic [19:0] wa;
      dswpc_w_t d0;
      logic [3:0] m0;
      dswpc_w_t d1;
      logic [3:0] m1;
   } dswpc_row_s;
   logic clk;
   logic reset;
   logic k_clk;
   logic k_clk_n;
   dswpc_pins_s pins;
   logic wr_done_ff;
   logic rd_start_ff;
   logic [19:0] wr_addr_ff;
   logic [19:0] rd_addr_ff;
   dswpc_w_t rd_word0_ff;
   dswpc_w_t rd_word1_ff;
   dswpc_w_t sh0 [16];
   dswpc_w_t sh1 [16];
   dswpc_w_t e0;
   dswpc_w_t e1;
   dswpc_row_s rows [6];
   dswpc_row_s r;
   logic [19:0] last_wa;
   logic [19:0] last_ra;
   int error_cnt = 0;
   int cmp_count = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;
   int ew;
   int er;
   dswpc_ctrl_model dswpc_ctrl_model_inst (.pins(pins), .k_clk(k_clk), .k_clk_n(k_clk_n));
   dswpc_top #(.MEM_AW(4)) dswpc_top_inst (.clk(clk), .reset(reset), .k_clk(k_clk),
      .k_clk_n(k_clk_n), .write_port_select_n(pins.write_port_select_n),
      .read_port_select_n(pins.read_port_select_n), .addr(pins.addr), .data(pins.data),
      .byte_write_mask_n(pins.byte_write_mask_n), .wr_done_ff(wr_done_ff),
      .wr_addr_ff(wr_addr_ff), .rd_start_ff(rd_start_ff), .rd_addr_ff(rd_addr_ff),
      .rd_word0_ff(rd_word0_ff), .rd_word1_ff(rd_word1_ff));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      wr_cnt <= wr_cnt + int'(wr_done_ff === 1'b1);
      rd_cnt <= rd_cnt + int'(rd_start_ff === 1'b1);
   end
   task automatic check(input dswpc_w_t seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   function automatic dswpc_w_t merge(input dswpc_w_t old, nw, input logic [3:0] m);
      dswpc_w_t v;
      v = old;
      for (int i = 0; i < 4; i++) if (!m[i]) v[i*9 +: 9] = nw[i*9 +: 9];
      return v;
   endfunction
   initial begin
      int n;
      int i;
      reset = 1'b1;
      last_wa = '0;
      last_ra = '0;
      rows = '{
         '{1'b0, 1'b1, 20'h0_0000, 20'h0_0003, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0},
         '{1'b0, 1'b0, 20'h0_0003, 20'h0_0003, 36'hF_FFFF_FFFF, 4'h5, 36'h0_0000_0000, 4'hA},
         '{1'b1, 1'b0, 20'h0_0003, 20'h0_0007, 36'h5_5555_5555, 4'h0, 36'h5_5555_5555, 4'h0},
         '{1'b0, 1'b0, 20'h0_0003, 20'h1_2345, 36'hA_BCDE_F012, 4'h0, 36'h3_4567_89AB, 4'h0},
         '{1'b0, 1'b0, 20'hF_FFF5, 20'hA_BCD5, 36'hF_FFFF_FFFF, 4'hE, 36'hF_FFFF_FFFF, 4'h7},
         '{1'b1, 1'b0, 20'h0_0005, 20'h0_0005, 36'h0_0000_0000, 4'h0, 36'h0_0000_0000, 4'h0}};
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      for (n = 0; n < 6; n++) begin
         r = rows[n];
         ew = wr_cnt + int'(!r.ws);
         er = rd_cnt + int'(!r.rs);
         e0 = sh0[r.ra[3:0]];
         e1 = sh1[r.ra[3:0]];
         #1 dswpc_ctrl_model_inst.frame(r.ws, r.rs, r.ra, r.wa, r.d0, r.d1, r.m0, r.m1);
         for (i = 0; i < 24 && (wr_cnt < ew || rd_cnt < er); i++) @(posedge clk);
         if (i == 24) begin
            error_cnt++;
            final_report();
         end
         repeat (6) @(posedge clk);
         if (!r.ws) begin
            sh0[r.wa[3:0]] = merge(sh0[r.wa[3:0]], r.d0, r.m0);
            sh1[r.wa[3:0]] = merge(sh1[r.wa[3:0]], r.d1, r.m1);
            last_wa = r.wa;
         end
         if (!r.rs) last_ra = r.ra;
         check(dswpc_w_t'(wr_cnt), dswpc_w_t'(ew));
         check(dswpc_w_t'(rd_cnt), dswpc_w_t'(er));
         check(dswpc_w_t'(wr_addr_ff), dswpc_w_t'(last_wa));
         check(dswpc_w_t'(rd_addr_ff), dswpc_w_t'(last_ra));
         if (!r.rs) begin
            check(rd_word0_ff, e0);
            check(rd_word1_ff, e1);
         end
         $display("Test %0d done", n);
      end
      #1 reset = 1'b1;
      repeat (4) @(posedge clk);
      check(dswpc_w_t'({wr_done_ff, rd_start_ff}), '0);
      check(dswpc_w_t'(wr_addr_ff), '0);
      check(dswpc_w_t'(rd_addr_ff), '0);
      check(rd_word0_ff | rd_word1_ff, '0);
      $display("Test reset done");
      final_report();
   end
endmodule
`default_nettype wire
